/* hw/twc_pkg.sv */
`default_nettype none
package twc_pkg;
  localparam int             REG_W        = 8;
  localparam int             PTR_W        = 4;
  localparam int             CONV_W       = 10;
  localparam logic [6:0]     SLAVE_BASE   = 7'h08;
  localparam int             ADR_BIT_1    = 6;
  localparam int             ADR_BIT_0    = 5;
  localparam logic [3:0]     REG_CTRL0    = 4'h0;
  localparam logic [3:0]     REG_CTRL1    = 4'h1;
  localparam logic [3:0]     REG_MON      = 4'hA;
  localparam logic [3:0]     REG_CONV     = 4'hD;
  localparam logic [3:0]     REG_RES_HI   = 4'hE;
  localparam logic [3:0]     REG_RES_LO   = 4'hF;
  localparam int             NUM_RW       = 14;
  localparam logic [7:0]     REG_RESET    = 8'h00;
  localparam int             MON_PD_BIT   = 1;
  localparam int             MON_BIAS_BIT = 0;
  localparam int             CONV_OFF_BIT = 7;
  localparam int             OSC_OFF_BIT  = 6;
  localparam int             RES_LO_W     = 2;
  localparam logic [2:0]     LAST_BIT     = 3'h7;
  localparam logic [2:0]     FIRST_BIT    = 3'h0;
  localparam logic [2:0]     BIT_STEP     = 3'h1;
  localparam int             TEMP_OFFSET  = 264;
  localparam int             TEMP_STEP    = 6;

  typedef enum logic [1:0] {
    MON_TEMP   = 2'b00,
    MON_SUPPLY = 2'b01,
    MON_PD     = 2'b10,
    MON_BIAS   = 2'b11
  } twc_mon_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_REG   = 3'b010,
    ST_WDATA = 3'b011,
    ST_ACK   = 3'b100,
    ST_RDATA = 3'b101,
    ST_WAIT  = 3'b110
  } twc_state_t;

  typedef struct packed {
    logic       chip_on;
    logic [1:0] photodiode_range;
    logic       open_loop_select;
    logic       fault_shutdown_on;
    logic       output_invert;
    logic       equalizer_on;
    logic       photodiode_direction;
  } twc_ctrl0_t;

  typedef struct packed {
    logic weak_pullup_select;
    logic high_follower_current_on;
    logic high_equalizer_gain_on;
    logic high_modulation_current_on;
    logic offset_cancel_off;
    logic bias_sink_select;
    logic output_stage_only_off;
    logic log_feature_on;
  } twc_ctrl1_t;

  // reference for models only, not synthesised into the port
  function automatic int twc_temp_c(input logic [9:0] reading);
    return (int'(reading) - TEMP_OFFSET) / TEMP_STEP;
  endfunction
endpackage
`default_nettype wire

/* hw/twc_port.sv */
// Overview of operation
// - monitor select routes source to converter
// - photodiode readout only when its bit set
// - bias readout only when its bit set
// - both off bits stop the converter
// - temperature equals reading minus 264, over 6
// - pull-up bit selects weak serial pull-ups
// - slave only; master clocks and frames
// - write: address, register, one byte, stop
// - grounded straps set the two leading address bits
// - data falls with clock high: start
// - data rises with clock high: stop
// - repeated start begins new address phase
// - one data byte per transfer, acknowledged
// - acknowledge held low through clock high
// - no address match leaves data high
// - extra bytes not acknowledged
// - read via repeated start returns one byte
// - control 0 field layout
// - control 1 field layout
// - registers 0x00 to 0x0D written, 0x00 to 0x0F read
// - power-up clears registers 0x00 to 0x0D
// - converter result split over 14 and 15
`timescale 1ns/100ps
`default_nettype none
module twc_port #(
  parameter int CONV_W = twc_pkg::CONV_W
) (
  input  wire logic               sys_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n_o,
  input  wire logic               address_strap_0_n_i,
  input  wire logic               address_strap_1_n_i,
  input  wire logic [CONV_W-1:0]  converter_reading_i,
  output twc_pkg::twc_ctrl0_t     primary_control_o,
  output twc_pkg::twc_ctrl1_t     secondary_control_o,
  output twc_pkg::twc_mon_t       monitor_source_select_o,
  output logic                    converter_stop_o,
  output logic                    photodiode_digital_readout_o,
  output logic                    bias_digital_readout_o,
  output logic                    weak_pullup_select_o
);
  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by second
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       scl_d;
  logic       sda_d;
  always_ff @(posedge sys_clk_i) begin
    pin_meta <= {scl_i, sda_i, address_strap_1_n_i, address_strap_0_n_i};
    pin_sync <= pin_meta;
  end
  wire scl_s = pin_sync[3];
  wire sda_s = pin_sync[2];

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // grounded strap (low) sets its address bit: strap 1 bit 6, strap 0 bit 5
  logic [6:0] slave_addr;
  always_comb begin
    slave_addr = twc_pkg::SLAVE_BASE;
    slave_addr[twc_pkg::ADR_BIT_1] = ~pin_sync[1];
    slave_addr[twc_pkg::ADR_BIT_0] = ~pin_sync[0];
  end

  //////////////////////////////////////////////////////////////////////////
  // protocol engine
  twc_pkg::twc_state_t state;
  twc_pkg::twc_state_t after_ack;
  logic [7:0]          shreg;
  logic [2:0]          bit_cnt;
  logic                byte_full;
  logic                pull_low;
  logic                wr_pend;
  logic [3:0]          reg_ptr;
  logic [7:0]          wr_data;
  logic [7:0]          regs [twc_pkg::NUM_RW];

  function automatic logic [7:0] read_sel(input logic [3:0] ptr,
                                          input logic [7:0] stored,
                                          input logic [CONV_W-1:0] conv);
    logic [7:0] r;
    r = stored;
    if (ptr == twc_pkg::REG_RES_HI)
      r = conv[CONV_W-1 -: 8];
    else if (ptr == twc_pkg::REG_RES_LO)
      r = {6'h00, conv[twc_pkg::RES_LO_W-1:0]};
    return r;
  endfunction

  wire       rx_state  = (state == twc_pkg::ST_ADDR) ||
                         (state == twc_pkg::ST_REG) ||
                         (state == twc_pkg::ST_WDATA);
  wire       addr_hit  = (shreg[7:1] == slave_addr);
  wire       rd_req    = shreg[0];
  wire       byte_evt  = scl_fall & byte_full & rx_state;
  wire       ack_end   = scl_fall & (state == twc_pkg::ST_ACK);
  wire       wr_commit = ack_end & wr_pend;
  wire [7:0] stored    = (reg_ptr < 4'(twc_pkg::NUM_RW)) ? regs[reg_ptr]
                                                         : twc_pkg::REG_RESET;
  wire [7:0] rd_byte   = read_sel(reg_ptr, stored, converter_reading_i);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state     <= twc_pkg::ST_IDLE;
      after_ack <= twc_pkg::ST_IDLE;
      shreg     <= 8'h00;
      bit_cnt   <= twc_pkg::FIRST_BIT;
      byte_full <= 1'b0;
      pull_low  <= 1'b0;
      wr_pend   <= 1'b0;
      reg_ptr   <= 4'h0;
      wr_data   <= 8'h00;
    end else if (start_c) begin
      state     <= twc_pkg::ST_ADDR;
      bit_cnt   <= twc_pkg::FIRST_BIT;
      byte_full <= 1'b0;
      pull_low  <= 1'b0;
      wr_pend   <= 1'b0;
    end else if (stop_c) begin
      state     <= twc_pkg::ST_IDLE;
      byte_full <= 1'b0;
      pull_low  <= 1'b0;
      wr_pend   <= 1'b0;
    end else begin
      unique case (state)
        twc_pkg::ST_IDLE, twc_pkg::ST_WAIT: begin
          pull_low <= 1'b0;
        end
        twc_pkg::ST_ADDR, twc_pkg::ST_REG, twc_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shreg     <= {shreg[6:0], sda_s};
            bit_cnt   <= bit_cnt + twc_pkg::BIT_STEP;
            byte_full <= (bit_cnt == twc_pkg::LAST_BIT);
          end else if (byte_evt) begin
            byte_full <= 1'b0;
            state     <= twc_pkg::ST_ACK;
            pull_low  <= 1'b1;
            if (state == twc_pkg::ST_ADDR) begin
              after_ack <= rd_req ? twc_pkg::ST_RDATA
                                  : twc_pkg::ST_REG;
              if (!addr_hit) begin
                state    <= twc_pkg::ST_WAIT;
                pull_low <= 1'b0;
              end
            end else if (state == twc_pkg::ST_REG) begin
              reg_ptr   <= shreg[3:0];
              after_ack <= twc_pkg::ST_WDATA;
              if (shreg[7:4] != 4'h0) begin
                state    <= twc_pkg::ST_WAIT;
                pull_low <= 1'b0;
              end
            end else begin
              wr_data   <= shreg;
              wr_pend   <= (reg_ptr < 4'(twc_pkg::NUM_RW));
              after_ack <= twc_pkg::ST_WAIT;
            end
          end
        end
        twc_pkg::ST_ACK: begin
          if (ack_end) begin
            wr_pend <= 1'b0;
            bit_cnt <= twc_pkg::FIRST_BIT;
            state   <= after_ack;
            if (after_ack == twc_pkg::ST_RDATA) begin
              shreg    <= rd_byte;
              pull_low <= ~rd_byte[7];
            end else begin
              pull_low <= 1'b0;
            end
          end
        end
        twc_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == twc_pkg::LAST_BIT) begin
              // master's ack is not needed: one byte per transfer
              pull_low <= 1'b0;
              state    <= twc_pkg::ST_WAIT;
            end else begin
              shreg    <= {shreg[6:0], 1'b0};
              pull_low <= ~shreg[6];
              bit_cnt  <= bit_cnt + twc_pkg::BIT_STEP;
            end
          end
        end
        default: begin
          state    <= twc_pkg::ST_IDLE;
          pull_low <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low, never drives high
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~pull_low;

  //////////////////////////////////////////////////////////////////////////
  // register file; 14 and 15 are read-only converter result
  for (genvar i = 0; i < twc_pkg::NUM_RW; i++) begin : g_reg
    always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i)
        regs[i] <= twc_pkg::REG_RESET;
      else if (wr_commit && reg_ptr == 4'(i))
        regs[i] <= wr_data;
    end
  end

  wire [7:0] conv_reg = regs[twc_pkg::REG_CONV];
  wire [7:0] mon_reg  = regs[twc_pkg::REG_MON];

  assign primary_control_o   = regs[twc_pkg::REG_CTRL0];
  assign secondary_control_o = regs[twc_pkg::REG_CTRL1];
  assign weak_pullup_select_o =
    secondary_control_o.weak_pullup_select;
  assign monitor_source_select_o =
    twc_pkg::twc_mon_t'(conv_reg[1:0]);
  assign converter_stop_o = conv_reg[twc_pkg::CONV_OFF_BIT] &
                            conv_reg[twc_pkg::OSC_OFF_BIT];
  assign photodiode_digital_readout_o =
    mon_reg[twc_pkg::MON_PD_BIT];
  assign bias_digital_readout_o =
    mon_reg[twc_pkg::MON_BIAS_BIT];

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_START_ADDR: assert property (
    start_c |=> state == twc_pkg::ST_ADDR &&
    bit_cnt == twc_pkg::FIRST_BIT && sda_oe_n_o)
    else $error("start did not open address phase");
  AST_STOP_IDLE: assert property (
    stop_c && !start_c |=> state == twc_pkg::ST_IDLE && sda_oe_n_o)
    else $error("stop did not return to idle");
  AST_NACK_MISS: assert property (
    byte_evt && state == twc_pkg::ST_ADDR && !addr_hit && !start_c &&
    !stop_c |=> sda_oe_n_o [*2])
    else $error("mismatched address was acknowledged");
  AST_REG_NACK: assert property (
    byte_evt && state == twc_pkg::ST_REG && shreg[7:4] != 4'h0
    |=> sda_oe_n_o [*2])
    else $error("out of range register address was acknowledged");
  AST_ACK_HIGH: assert property (
    state == twc_pkg::ST_ACK && scl_s |-> !sda_oe_n_o)
    else $error("ack released during clock high");
  AST_WAIT_QUIET: assert property (
    state == twc_pkg::ST_WAIT |-> sda_oe_n_o)
    else $error("data line driven after the single byte");
  AST_RD_SHIFT: assert property (
    state == twc_pkg::ST_RDATA && scl_fall && bit_cnt != twc_pkg::LAST_BIT
    |=> sda_oe_n_o == $past(shreg[6]))
    else $error("read byte bit not presented");
  AST_RD_RELEASE: assert property (
    state == twc_pkg::ST_RDATA && scl_fall && bit_cnt == twc_pkg::LAST_BIT
    |=> state == twc_pkg::ST_WAIT && sda_oe_n_o)
    else $error("data line held after the read byte");
  AST_RO_SAFE: assert property (
    wr_commit |-> reg_ptr < 4'(twc_pkg::NUM_RW))
    else $error("write reached read-only register");
  AST_PULLUP: assert property (
    wr_commit && reg_ptr == twc_pkg::REG_CTRL1
    |=> weak_pullup_select_o == $past(wr_data[7]))
    else $error("pull-up select not updated");
  AST_CONV_STOP: assert property (
    wr_commit && reg_ptr == twc_pkg::REG_CONV
    |=> converter_stop_o == ($past(wr_data[7]) && $past(wr_data[6])) &&
        monitor_source_select_o == $past(wr_data[1:0]))
    else $error("converter settings not applied");
  AST_READOUT: assert property (
    wr_commit && reg_ptr == twc_pkg::REG_MON
    |=> photodiode_digital_readout_o == $past(wr_data[twc_pkg::MON_PD_BIT]) &&
        bias_digital_readout_o == $past(wr_data[twc_pkg::MON_BIAS_BIT]))
    else $error("monitor readout bits not applied");
  AST_WR_AFTER_ACK: assert property (
    $changed(regs[twc_pkg::REG_CTRL0]) |-> $past(wr_commit))
    else $error("register changed without acknowledged write");
  AST_RESET_ZERO: assert property (
    $fell(sys_rst_i) |-> primary_control_o == twc_pkg::REG_RESET &&
    !converter_stop_o)
    else $error("registers not cleared by reset");
  AST_READ_MSB: assert property (
    ack_end && after_ack == twc_pkg::ST_RDATA && !start_c && !stop_c
    |=> sda_oe_n_o == $past(rd_byte[7]))
    else $error("read byte msb not presented");

  COV_WRITE: cover property (wr_commit);
  COV_READ: cover property (state == twc_pkg::ST_RDATA ##1
    state == twc_pkg::ST_WAIT);
  COV_NACK: cover property (byte_evt && state == twc_pkg::ST_ADDR &&
    !addr_hit);
  COV_RESTART: cover property (state == twc_pkg::ST_WAIT && start_c);
  COV_RESULT: cover property (ack_end && after_ack == twc_pkg::ST_RDATA &&
    reg_ptr == twc_pkg::REG_RES_HI);
endmodule // twc_port
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                sys_clk_i = 1'b0;
  logic                sys_rst_i = 1'b1;
  logic                strap0_n  = 1'b1;
  logic                strap1_n  = 1'b1;
  logic [9:0]          reading   = 10'h000;
  logic                scl, m_sda, sda_o, sda_oe_n;
  logic                conv_stop, pdr, bsr, wpu;
  twc_pkg::twc_ctrl0_t c0;
  twc_pkg::twc_ctrl1_t c1;
  twc_pkg::twc_mon_t   msel;
  logic [7:0]          mdl [16];
  logic [6:0]          dev = 7'h08;
  int                  n_mismatch = 0;
  int                  num_checks = 0;
  int                  cyc = 0;
  int                  seed = 96130;
  // pull-up on the wire: low if either party pulls
  wire logic           sda_line = m_sda & (sda_oe_n | sda_o);

  always #20 sys_clk_i = ~sys_clk_i;

  twc_master mst (.sys_clk_i(sys_clk_i), .sda_line_i(sda_line),
                  .scl_o(scl), .sda_o(m_sda));
  twc_port #(.CONV_W(10)) DUT (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .address_strap_0_n_i(strap0_n), .address_strap_1_n_i(strap1_n),
    .converter_reading_i(reading), .primary_control_o(c0),
    .secondary_control_o(c1), .monitor_source_select_o(msel),
    .converter_stop_o(conv_stop), .photodiode_digital_readout_o(pdr),
    .bias_digital_readout_o(bsr), .weak_pullup_select_o(wpu));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic outs();
    chk(c0, mdl[0]);
    chk(c1, mdl[1]);
    chk(8'(msel), 8'(mdl[13][1:0]));
    chk(8'(conv_stop), 8'(mdl[13][7] & mdl[13][6]));
    chk(8'(pdr), 8'(mdl[10][1]));
    chk(8'(bsr), 8'(mdl[10][0]));
    chk(8'(wpu), 8'(mdl[1][7]));
    chk(8'(sda_o), 8'h00);
  endtask
  // extra sends a second data byte that must be refused
  task automatic wr(input logic [6:0] a, input logic [7:0] r,
                    input logic [7:0] d, input logic extra);
    logic ak;
    mst.start();
    mst.put({a, 1'b0}, ak);
    chk(8'(ak), 8'(a == dev));
    if (ak) begin
      mst.put(r, ak);
      chk(8'(ak), 8'(r < 8'h10));
      if (ak) begin
        mst.put(d, ak);
        chk(8'(ak), 8'h01);
        if (r < 8'h0E) begin
          mdl[r[3:0]] = d;
        end
        if (extra) begin
          mst.put(~d, ak);
          chk(8'(ak), 8'h00);
        end
      end
    end
    mst.stop();
    outs();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic ak;
    mst.start();
    mst.put({dev, 1'b0}, ak);
    mst.put(r, ak);
    mst.start();
    mst.put({dev, 1'b1}, ak);
    chk(8'(ak), 8'h01);
    mst.get(d);
    mst.stop();
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0]  d;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [15:0] tbl [7];
    logic        ak;
    tbl = '{16'h0D01, 16'h0D02, 16'h0D03, 16'h0DC0, 16'h0D80,
            16'h0A02, 16'h0A01};
    hi = 8'h00;
    lo = 8'h00;
    mdl = '{default: 8'h00};
    repeat (3) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    outs();
    reading = 10'($random(seed));
    mdl[14] = reading[9:2];
    mdl[15] = {6'h00, reading[1:0]};
    for (int r = 0; r < 16; r++) begin
      wr(dev, r[7:0], 8'($random(seed)), r == 5);
    end
    for (int r = 0; r < 16; r++) begin
      rd(r[7:0], d);
      chk(d, mdl[r]);
      if (r == 14) begin
        hi = d;
      end
      if (r == 15) begin
        lo = d;
      end
    end
    chk(8'((int'({hi, lo[1:0]}) - 264) / 6),
        8'((int'(reading) - 264) / 6));
    for (int i = 0; i < 7; i++) begin
      wr(dev, tbl[i][15:8], tbl[i][7:0], 1'b0);
    end
    wr(dev, 8'h10, 8'h55, 1'b0);
    for (int s = 1; s < 3; s++) begin
      {strap1_n, strap0_n} = s[1:0];
      repeat (4) @(negedge sys_clk_i);
      dev = 7'h08 | {~s[1], ~s[0], 5'h00};
      wr(7'h08, 8'h00, 8'h00, 1'b0);
      wr(dev, 8'h01, 8'($random(seed)), 1'b0);
    end
    // refused address, then a repeated start from the wait state
    mst.start();
    mst.put({7'h08, 1'b0}, ak);
    chk(8'(ak), 8'h00);
    rd(8'h01, d);
    chk(d, mdl[1]);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire

/* tb/twc_master.sv */
`timescale 1ns/100ps
`default_nettype none
module twc_master (
  input  wire logic sys_clk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // one tick is 320 ns, eight system clocks; nothing moves between frames
  task automatic tk(input int n);
    repeat (n * 8) @(negedge sys_clk_i);
  endtask
  // data moves mid-low, far from both clock edges
  task automatic bit_io(input logic b, output logic s);
    tk(2);
    sda_o = b;
    tk(3);
    scl_o = 1'b1;
    tk(1);
    s = sda_line_i;
    tk(2);
    scl_o = 1'b0;
  endtask
  task automatic start();
    tk(2);
    sda_o = 1'b1;
    tk(3);
    scl_o = 1'b1;
    tk(3);
    sda_o = 1'b0;
    tk(3);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    tk(2);
    sda_o = 1'b0;
    tk(3);
    scl_o = 1'b1;
    tk(3);
    sda_o = 1'b1;
    tk(5);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic get(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(1'b1, s);
  endtask
endmodule // twc_master
`default_nettype wire
